// [design/sbc_pkg.sv]
package sbc_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] SBC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] SBC_OFF_LOW    = 8'h04;
  localparam logic [7:0] SBC_OFF_HIGH   = 8'h08;
  localparam logic [7:0] SBC_OFF_STATUS = 8'h0c;
  localparam logic [7:0] SBC_OFF_MASK   = 8'h10;

  // Control register field positions.
  localparam int SBC_CTRL_RUN     = 0;
  localparam int SBC_CTRL_EXT_SRC = 1;
  localparam int SBC_CTRL_BYPASS  = 2;
  localparam int SBC_CTRL_OSC_EN  = 3;
  localparam int SBC_CTRL_DIV_LSB = 4;
  localparam int SBC_CTRL_WIDTH   = 6;

  // Status and mask field position.
  localparam int SBC_STAT_OVF = 0;

  // Reset values.
  localparam logic [5:0]  SBC_CTRL_RESET  = 6'h00;
  localparam logic [15:0] SBC_COUNT_RESET = 16'h0000;
  localparam logic [0:0]  SBC_MASK_RESET  = 1'h0;

  // Clock and timing figures.
  localparam int SBC_HCLK_HZ         = 40000000;
  localparam int SBC_CRYSTAL_HZ      = 32768;
  localparam int SBC_STARTUP_CYCLES  = 1024;
  localparam logic [15:0] SBC_STARTUP_PRELOAD = 16'hfc00;

  // Prescale divider width, enough for a ratio of 8.
  localparam int SBC_PRE_W = 3;

  // Control bits as one carrier.
  typedef struct packed {
    logic [1:0] clock_divide_select;
    logic       crystal_osc_enable;
    logic       sync_bypass;
    logic       ext_source;
    logic       run;
  } sbc_ctrl_t;

  // Latched AHB address phase.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] offset;
  } sbc_aphase_t;

endpackage : sbc_pkg

// [design/sbc_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none

module sbc_prescaler import sbc_pkg::*; #(
  parameter int W = SBC_PRE_W
) (
  // Clock and reset.
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Source ticks and control.
  input  wire logic       tick_in,
  input  wire logic       clear,
  input  wire logic [1:0] div_sel,
  // Divided tick.
  output logic            tick_out
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Mask of low counter bits that must all be set for a ratio of 2 to the sel.
  function automatic logic [W-1:0] sbc_div_mask(input logic [1:0] sel);
    sbc_div_mask = W'((1 << sel) - 1);
  endfunction : sbc_div_mask

  // A clear beats a tick so the first tick after a counter write starts afresh.
  always_comb begin
    cnt_d    = cnt_q;
    tick_out = 1'b0;
    if (clear) begin
      cnt_d = '0;
    end else if (tick_in) begin
      tick_out = ((cnt_q & sbc_div_mask(div_sel)) == sbc_div_mask(div_sel));
      cnt_d    = tick_out ? '0 : cnt_q + W'(1);
    end
  end

  // Registers the prescale count; software can neither read nor write it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : sbc_prescaler

`default_nettype wire

// [design/sbc_counter.sv]
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Input clock divided by 1, 2, 4 or 8 per two-bit select.
// - Prescale count hidden from software; cleared by any counter byte write.
// - Crystal amplifier between crystal pins runs when oscillator enable is set.
// - Crystal amplifier keeps running while the processor sleeps.
// - Bypass bit set skips external clock synchronisation for counting.
// - Async external counting continues in sleep; overflow can wake processor.
// - Byte reads always return a valid count while running asynchronously.
// - Write colliding with increment wins; the increment is dropped.
// - Counter advances on prescaled source edge when running, else holds.
module sbc_counter import sbc_pkg::*; (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Clock sources and crystal pins.
  input  wire logic        ext_clk_pin,
  input  wire logic        crystal_in_pin,
  output logic             crystal_drive_pin,
  // Power state and interrupt.
  input  wire logic        sleep_mode,
  output logic             irq,
  output logic             wake_req
);

  sbc_ctrl_t   ctrl_q, ctrl_d;
  sbc_aphase_t ap_q, ap_d;
  logic [15:0] count_q, count_d;
  logic [0:0]  stat_q, stat_d;
  logic [0:0]  mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ext_level;
  logic        sync1_q, sync2_q, sync3_q;
  logic        raw1_q, raw2_q;
  logic        sync_edge, raw_edge;
  logic        src_tick, pre_tick;
  logic        take, wr_low, wr_high, rd_status;
  logic        overflow;

  // The crystal pin is the external source whenever the amplifier is on.
  assign ext_level = ctrl_q.crystal_osc_enable ? crystal_in_pin : ext_clk_pin;

  // ignores sleep
  // Inverting drive; sleep does not gate it, so a watch crystal keeps time.
  assign crystal_drive_pin = ctrl_q.crystal_osc_enable & ~crystal_in_pin;

  // Two-stage synchroniser plus a delay stage for the rising-edge detector.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      raw1_q  <= 1'b0;
      raw2_q  <= 1'b0;
    end else begin
      sync1_q <= ext_level;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      raw1_q  <= ext_level;
      raw2_q  <= raw1_q;
    end
  end

  // Rising edges of the synchronised and raw source. Both chains rest low after
  // reset, so a pin idling low gives no false edge when counting starts.
  assign sync_edge = sync2_q & ~sync3_q;
  assign raw_edge  = raw1_q & ~raw2_q;

  // switch latency
  // The bypass path is one cycle shorter, so an edge in flight during a mode
  // switch can be seen twice or not at all. Synchronous counting and the
  // internal source both depend on the core clocks, which stop in sleep.
  always_comb begin
    if (!ctrl_q.ext_source) begin
      src_tick = ~sleep_mode;
    end else if (ctrl_q.sync_bypass) begin
      src_tick = raw_edge;
    end else begin
      src_tick = sync_edge & ~sleep_mode;
    end
  end

  sbc_prescaler #(
    .W (SBC_PRE_W)
  ) u_prescaler (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick_in  (src_tick & ctrl_q.run),
    .clear    (wr_low | wr_high),
    .div_sel  (ctrl_q.clock_divide_select),
    .tick_out (pre_tick)
  );

  // Bus decode: a transfer is taken when selected, NONSEQ or SEQ and the bus is ready.
  assign take      = hsel & hready & htrans[1];
  assign wr_low    = ap_q.valid & ap_q.write & (ap_q.offset == SBC_OFF_LOW);
  assign wr_high   = ap_q.valid & ap_q.write & (ap_q.offset == SBC_OFF_HIGH);
  assign rd_status = take & ~hwrite & (haddr[7:0] == SBC_OFF_STATUS);
  assign overflow  = pre_tick & (count_q == 16'hffff);

  // Read data is gathered in the address phase, so a single-cycle data phase
  // still hands out registered data. Unmapped offsets read as zero.
  always_comb begin
    rdata_d = rdata_q;
    if (take && !hwrite) begin
      case (haddr[7:0])
        SBC_OFF_CTRL:   rdata_d = {26'h0, ctrl_q};
        SBC_OFF_LOW:    rdata_d = {24'h0, count_q[7:0]};
        SBC_OFF_HIGH:   rdata_d = {24'h0, count_q[15:8]};
        SBC_OFF_STATUS: rdata_d = {31'h0, stat_q};
        SBC_OFF_MASK:   rdata_d = {31'h0, mask_q};
        default:        rdata_d = 32'h0;
      endcase
    end
  end

  // Address phase latch and control, mask writes in the data phase.
  always_comb begin
    ap_d       = '0;
    ap_d.valid = take;
    ap_d.write = hwrite;
    ap_d.offset = haddr[7:0];
    ctrl_d     = ctrl_q;
    mask_d     = mask_q;
    if (ap_q.valid && ap_q.write && ap_q.offset == SBC_OFF_CTRL) begin
      ctrl_d = hwdata[SBC_CTRL_WIDTH-1:0];
    end
    if (ap_q.valid && ap_q.write && ap_q.offset == SBC_OFF_MASK) begin
      mask_d = hwdata[SBC_STAT_OVF];
    end
  end

  // rollover sets flag
  // A byte write overrides a coincident increment; the count is then whatever
  // was written, which software must avoid by stopping the counter first.
  // The flag is cleared by a status read, but a rollover in that same cycle
  // sets it again so the event is not lost.
  always_comb begin
    count_d = count_q;
    stat_d  = stat_q;
    if (wr_low) begin
      count_d[7:0] = hwdata[7:0];
    end else if (wr_high) begin
      count_d[15:8] = hwdata[7:0];
    end else if (pre_tick) begin
      count_d = count_q + 16'h0001;
    end
    if (rd_status) begin
      stat_d = 1'b0;
    end
    if (overflow) begin
      stat_d = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= SBC_CTRL_RESET;
      ap_q    <= '0;
      count_q <= SBC_COUNT_RESET;
      stat_q  <= 1'b0;
      mask_q  <= SBC_MASK_RESET;
      rdata_q <= 32'h0;
    end else begin
      ctrl_q  <= ctrl_d;
      ap_q    <= ap_d;
      count_q <= count_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  // The slave never inserts wait states and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // overflow wakes processor
  // Both are levels built from registers and the sleep_mode input, so they stay clean while the core sleeps.
  assign irq      = |(stat_q & mask_q);
  assign wake_req = irq & sleep_mode;

  // Checks on the design's own outputs and state.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Source ticks since the last prescaled tick or counter write. The ratio
  // check reads this instead of the prescaler's hidden count.
  int unsigned tick_gap;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_gap <= 0;
    end else if (pre_tick || wr_low || wr_high) begin
      tick_gap <= 0;
    end else if (src_tick && ctrl_q.run) begin
      tick_gap <= tick_gap + 1;
    end
  end

  // Prescaler ratio and restart.
  a_prescale_ratio_max: assert property (
    tick_gap < (1 << ctrl_q.clock_divide_select))
    else $error("Prescaler passed more source ticks than its ratio.");
  a_div_one_direct: assert property (
    (ctrl_q.clock_divide_select == 2'h0 && ctrl_q.run && src_tick && !wr_low && !wr_high)
    |-> pre_tick)
    else $error("Divide-by-one did not pass a source tick.");
  a_write_clears_pre: assert property (
    (wr_low || wr_high) |-> !pre_tick ##1 tick_gap == 0)
    else $error("Counter write did not restart the prescaler.");

  // Crystal amplifier, awake and asleep.
  a_crystal_drive_on: assert property (
    !ctrl_q.crystal_osc_enable |-> !crystal_drive_pin)
    else $error("Crystal amplifier driving while disabled.");
  a_osc_sleep_runs: assert property (
    (ctrl_q.crystal_osc_enable && sleep_mode) |-> crystal_drive_pin == !crystal_in_pin)
    else $error("Crystal amplifier stopped in sleep.");

  // Source selection, bypass and sleep behaviour.
  a_bypass_edge_path: assert property (
    (ctrl_q.ext_source && ctrl_q.sync_bypass && $rose(raw1_q)) |-> src_tick)
    else $error("Bypass mode missed a raw external edge.");
  a_sync_edge_path: assert property (
    (ctrl_q.ext_source && !ctrl_q.sync_bypass && !sleep_mode && sync_edge) |-> src_tick)
    else $error("Synchronised mode missed an external edge.");
  a_sleep_stops_sync: assert property (
    (sleep_mode && !(ctrl_q.ext_source && ctrl_q.sync_bypass)) |-> !src_tick)
    else $error("Core-clocked counting went on in sleep.");
  a_sleep_bypass_count: assert property (
    (sleep_mode && ctrl_q.run && ctrl_q.ext_source && ctrl_q.sync_bypass && raw_edge
     && ctrl_q.clock_divide_select == 2'h0 && !wr_low && !wr_high) |-> pre_tick)
    else $error("Asynchronous counting stopped in sleep.");
  a_sleep_async_wake: assert property (
    (stat_q[0] && mask_q[0] && sleep_mode) |-> wake_req)
    else $error("Unmasked overflow in sleep did not request wake.");
  a_irq_masked: assert property (
    !mask_q[0] |-> (!irq && !wake_req))
    else $error("Masked overflow raised an interrupt.");

  // Counting, holding and rollover.
  a_hold_no_run: assert property (
    (!ctrl_q.run && !wr_low && !wr_high) |=> $stable(count_q))
    else $error("Counter moved while stopped.");
  a_stop_no_tick: assert property (
    !ctrl_q.run |-> !pre_tick)
    else $error("Prescaler ticked while the counter was stopped.");
  a_count_increment: assert property (
    (pre_tick && !wr_low && !wr_high)
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("Counter did not advance by one.");
  a_rollover_flag: assert property (
    overflow |=> stat_q[0] && count_q == 16'h0000)
    else $error("Rollover did not set the overflow flag.");
  a_status_read_clear: assert property (
    (rd_status && !overflow) |=> !stat_q[0])
    else $error("Status read did not clear the overflow flag.");

  // Register reads and byte writes.
  a_read_valid_byte: assert property (
    (take && !hwrite && haddr[7:0] == SBC_OFF_HIGH)
    |=> hrdata == {24'h0, $past(count_q[15:8])})
    else $error("High byte read returned a stale value.");
  a_read_valid_low: assert property (
    (take && !hwrite && haddr[7:0] == SBC_OFF_LOW)
    |=> hrdata == {24'h0, $past(count_q[7:0])})
    else $error("Low byte read returned a stale value.");
  a_write_low_byte: assert property (
    wr_low |=> count_q[7:0] == $past(hwdata[7:0]))
    else $error("Low byte write lost to an increment.");
  a_write_high_byte: assert property (
    wr_high |=> count_q[15:8] == $past(hwdata[7:0]) && count_q[7:0] == $past(count_q[7:0]))
    else $error("High byte write lost or disturbed the low byte.");

  c_overflow_irq: cover property (overflow ##1 irq);
  c_async_sleep_count: cover property (sleep_mode && ctrl_q.sync_bypass && pre_tick);
  c_div_eight_tick: cover property (ctrl_q.clock_divide_select == 2'h3 && pre_tick);
  c_status_read_clear: cover property (rd_status && stat_q[0]);

endmodule : sbc_counter

`default_nettype wire

// [verification/sbc_xtal_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Far side: crystal and external pin; each stands still while switched off.
module sbc_xtal_model #(
  parameter int XHALF = 103,
  parameter int PHALF = 163
) (
  // Source enables from the bench.
  input  wire logic xtal_on,
  input  wire logic pin_on,
  // Pins toward the counter.
  output logic      crystal_in_pin,
  output logic      ext_clk_pin
);
  // Crystal oscillation.
  // It never sees sleep, so it keeps running while the core sleeps.
  initial crystal_in_pin = 1'b0;
  always #(XHALF) if (xtal_on) crystal_in_pin = ~crystal_in_pin;
  // Odd half periods keep both sources unrelated in phase to hclk.
  initial ext_clk_pin = 1'b0;
  always #(PHALF) if (pin_on) ext_clk_pin = ~ext_clk_pin;
endmodule : sbc_xtal_model
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb import sbc_pkg::*; ();
  typedef struct packed {
    logic [7:0]  off;
    logic [31:0] wd;
    logic [31:0] ex;
  } sbc_row_t;
  localparam sbc_row_t ROWS [0:6] = '{
    '{SBC_OFF_CTRL, 32'hffff_ffc6, 32'h06}, '{SBC_OFF_CTRL, 32'h3e, 32'h3e},
    '{SBC_OFF_LOW, 32'h1ab, 32'hab}, '{SBC_OFF_HIGH, 32'h2cd, 32'hcd},
    '{SBC_OFF_MASK, 32'hfe, 32'h0}, '{8'h14, 32'h55, 32'h0},
    '{SBC_OFF_MASK, 32'h3, 32'h1}};
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        sleep_mode = 1'b0, xtal_on = 1'b0, pin_on = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        hreadyout, hresp, crystal_in_pin, crystal_drive_pin;
  logic        ext_clk_pin, irq, wake_req;
  int          error_cnt = 0, compares = 0;
  // 40 MHz bus clock.
  always #12.5 hclk = ~hclk;
  sbc_counter i_sbc_counter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_clk_pin(ext_clk_pin), .crystal_in_pin(crystal_in_pin),
    .crystal_drive_pin(crystal_drive_pin), .sleep_mode(sleep_mode), .irq(irq),
    .wake_req(wake_req));
  sbc_xtal_model i_sbc_xtal_model (.xtal_on(xtal_on), .pin_on(pin_on),
    .crystal_in_pin(crystal_in_pin), .ext_clk_pin(ext_clk_pin));
  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Mode switches may gain or drop one increment, so counts get a window.
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    compares++;
    if (((g >= lo) && (g <= hi)) !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  // One single AHB-Lite transfer; address phase held until hready is seen.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd_chk
  // Main sequence.
  initial begin : main
    logic [31:0] q;
    int k;
    logic [31:0] hi, lo;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (k = 0; k < 5; k++) rd_chk("reset value", 8'(4 * k), 32'h0);
    chk("irq at reset", 32'h0, {31'h0, irq});
    chk("okay response", 32'h0, {31'h0, hresp});
    chk("no wait state", 32'h1, {31'h0, hreadyout});
    foreach (ROWS[i]) begin
      wr(ROWS[i].off, ROWS[i].wd);
      rd_chk("register", ROWS[i].off, ROWS[i].ex);
    end
    // Every divide ratio over about 80 source cycles; byte writes clear the prescaler.
    for (k = 0; k < 4; k++) begin
      wr(SBC_OFF_LOW, 32'h0);
      wr(SBC_OFF_HIGH, 32'h0);
      wr(SBC_OFF_CTRL, 32'(k << 4) | 32'h1);
      repeat (77) @(posedge hclk);
      wr(SBC_OFF_CTRL, 32'h0);
      bus(1'b0, SBC_OFF_LOW, 32'h0, q);
      chk_rng("prescaled count", (80 >> k) - 2, (80 >> k) + 2, q);
    end
    // A running count read as two bytes; the high byte is read again and the
    // low byte re-read when it moved, so a carry between the reads is not torn.
    wr(SBC_OFF_LOW, 32'hfa);
    wr(SBC_OFF_HIGH, 32'h01);
    wr(SBC_OFF_CTRL, 32'h1);
    bus(1'b0, SBC_OFF_HIGH, 32'h0, hi);
    bus(1'b0, SBC_OFF_LOW, 32'h0, lo);
    bus(1'b0, SBC_OFF_HIGH, 32'h0, q);
    if (q !== hi) begin
      hi = q;
      bus(1'b0, SBC_OFF_LOW, 32'h0, lo);
    end
    wr(SBC_OFF_CTRL, 32'h0);
    chk_rng("two-byte read", 32'h1fb, 32'h209, {16'h0, hi[7:0], lo[7:0]});
    rd_chk("high after carry", SBC_OFF_HIGH, 32'h02);
    // Rollover with the interrupt masked, then unmasked.
    for (k = 0; k < 2; k++) begin
      wr(SBC_OFF_MASK, 32'(k));
      wr(SBC_OFF_LOW, 32'hfe);
      wr(SBC_OFF_HIGH, 32'hff);
      wr(SBC_OFF_CTRL, 32'h1);
      repeat (6) @(posedge hclk);
      wr(SBC_OFF_CTRL, 32'h0);
      @(negedge hclk);
      chk("irq on overflow", 32'(k), {31'h0, irq});
      rd_chk("overflow flag", SBC_OFF_STATUS, 32'h1);
      rd_chk("flag after read", SBC_OFF_STATUS, 32'h0);
      @(negedge hclk);
      chk("irq after read", 32'h0, {31'h0, irq});
    end
    // Synchronised pin counting stands still in sleep and resumes awake.
    wr(SBC_OFF_LOW, 32'h0);
    wr(SBC_OFF_CTRL, 32'h3);
    sleep_mode <= 1'b1;
    pin_on <= 1'b1;
    #(100 * 326);
    rd_chk("sync count in sleep", SBC_OFF_LOW, 32'h0);
    @(posedge hclk);
    sleep_mode <= 1'b0;
    #(100 * 326);
    wr(SBC_OFF_CTRL, 32'h0);
    pin_on <= 1'b0;
    bus(1'b0, SBC_OFF_LOW, 32'h0, q);
    chk_rng("sync pin count", 97, 103, q);
    // Crystal start-up wait in sleep with the synchroniser bypassed.
    rd_chk("flag before start-up", SBC_OFF_STATUS, 32'h0);
    wr(SBC_OFF_LOW, 32'h0);
    wr(SBC_OFF_HIGH, 32'hfc);
    wr(SBC_OFF_CTRL, 32'h0f);
    xtal_on <= 1'b1;
    sleep_mode <= 1'b1;
    @(negedge hclk);
    chk("crystal drive", {31'h0, ~crystal_in_pin}, {31'h0, crystal_drive_pin});
    #(1000 * 206);
    @(negedge hclk);
    chk("wake before start-up", 32'h0, {31'h0, wake_req});
    k = 0;
    while (wake_req !== 1'b1 && k < 400) begin
      @(negedge hclk);
      k++;
    end
    chk("wake from sleep", 32'h1, {31'h0, wake_req});
    chk("irq in sleep", 32'h1, {31'h0, irq});
    @(posedge hclk);
    sleep_mode <= 1'b0;
    xtal_on <= 1'b0;
    wr(SBC_OFF_CTRL, 32'h0);
    @(negedge hclk);
    chk("drive when off", 32'h0, {31'h0, crystal_drive_pin});
    // Second reset while counting.
    wr(SBC_OFF_CTRL, 32'h1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("ctrl after reset", SBC_OFF_CTRL, 32'h0);
    rd_chk("low after reset", SBC_OFF_LOW, 32'h0);
    complete_run();
  end
  // Watchdog well beyond the expected run of about 300 us.
  initial begin : watchdog
    #(1000000);
    error_cnt++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
